//--- include/dft_pkg.sv
package dft_pkg;
    // error codes shown on the display and stored in the history
    localparam logic [7:0] DFT_CODE_NONE = 8'h00;
    localparam logic [7:0] DFT_CODE_OC_CONST = 8'h01;
    localparam logic [7:0] DFT_CODE_OC_DECEL = 8'h02;
    localparam logic [7:0] DFT_CODE_OC_ACCEL = 8'h03;
    localparam logic [7:0] DFT_CODE_OC_OTHER = 8'h04;
    localparam logic [7:0] DFT_CODE_OVERLOAD = 8'h05;
    localparam logic [7:0] DFT_CODE_BUS_OV = 8'h07;
    localparam logic [7:0] DFT_CODE_MEM = 8'h08;
    localparam logic [7:0] DFT_CODE_BUS_UV = 8'h09;
    localparam logic [7:0] DFT_CODE_CPU = 8'h11;
    localparam logic [7:0] DFT_CODE_EXT = 8'h12;
    localparam logic [7:0] DFT_CODE_START = 8'h13;
    localparam logic [7:0] DFT_CODE_GROUND = 8'h14;
    localparam logic [7:0] DFT_CODE_IN_OV = 8'h15;
    localparam logic [7:0] DFT_CODE_MOD_HOT = 8'h21;
    localparam logic [7:0] DFT_CODE_DRIVER = 8'h30;
    localparam logic [7:0] DFT_CODE_THERMISTOR = 8'h35;
    localparam logic [7:0] DFT_CODE_ESTOP = 8'h37;
    localparam logic [7:0] DFT_CODE_COMM = 8'h60;
    // motion phase encoding
    localparam logic [1:0] DFT_PHASE_CONST = 2'h0;
    localparam logic [1:0] DFT_PHASE_DECEL = 2'h1;
    localparam logic [1:0] DFT_PHASE_ACCEL = 2'h2;
    // init select value that clears only the history
    localparam logic [1:0] DFT_INIT_CLEAR_HISTORY = 2'h0;
    // timing: clock and stop time before input over-voltage test
    localparam longint DFT_CLK_HZ = 10000000;
    localparam longint DFT_STOP_TEST_S = 100;
    localparam longint DFT_STOP_TEST_CYC = DFT_STOP_TEST_S * DFT_CLK_HZ;
    localparam int DFT_STOP_CNT_W = 30;
    // widths
    localparam int DFT_SNAP_W = 16;
    // reset values
    localparam logic [7:0] DFT_RST_CODE = 8'h00;
    localparam logic [15:0] DFT_RST_SNAP = 16'h0000;
endpackage

//--- core/dft_trip.sv
`timescale 1ns/1ps
`default_nettype none
module dft_trip
    import dft_pkg::*;
#(
    parameter longint STOP_TEST_CYC = DFT_STOP_TEST_CYC
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // fault sources (asynchronous pins)
    input wire logic over_current,
    input wire logic [1:0] motion_phase,
    input wire logic motor_overload,
    input wire logic bus_over_voltage,
    input wire logic bus_under_voltage,
    input wire logic mem_fault,
    input wire logic cpu_fault,
    input wire logic external_trip_input,
    input wire logic ground_fault,
    input wire logic input_over_voltage,
    input wire logic module_over_temp,
    input wire logic thermistor_hot,
    input wire logic driver_path_error,
    input wire logic emergency_stop,
    input wire logic comm_watchdog_expired,
    input wire logic brownout_restart_failed,
    // operator and configuration
    input wire logic run_command,
    input wire logic motor_running,
    input wire logic unattended_start_guard,
    input wire logic reset_input_terminal,
    input wire logic reset_held_at_power_off,
    input wire logic power_up_test,
    input wire logic stop_reset_key,
    input wire logic [1:0] init_select_setting,
    input wire logic init_execute,
    // operating data to snapshot
    input wire logic [15:0] operating_data,
    // outputs
    output logic tripped,
    output logic output_enable,
    output logic run_allowed,
    output logic [7:0] display_code,
    output logic [15:0] fault_snapshot,
    output logic [7:0] newest_fault_record,
    output logic [7:0] middle_fault_record,
    output logic [7:0] oldest_fault_record
);
    // fault vector bit order, highest priority first in the encoder except brownout, taken right after bus under-voltage, and input over-voltage, taken last
    localparam int NF = 18;

    // whole state of the block
    typedef struct packed {
        logic [NF-1:0] s1;          // first sync stage
        logic [NF-1:0] s2;          // second sync stage
        logic [1:0] ph1;            // phase sync stage 1
        logic [1:0] ph2;            // phase sync stage 2
        logic key1;                 // key sync
        logic key2;
        logic key3;                 // key edge history
        logic init1;                // init request sync
        logic init2;
        logic init3;
        logic boot1;                // reset just released
        logic boot2;                // sync pipe half full
        logic first;                // sync pipe full: power-up checks now
        logic tripped;
        logic oe;                   // output stage enable
        logic [7:0] code;           // latched display code
        logic [15:0] snap;          // operating data snapshot
        logic [7:0] h0;             // newest
        logic [7:0] h1;             // middle
        logic [7:0] h2;             // oldest
        logic [DFT_STOP_CNT_W-1:0] stop_cnt; // time spent stopped
        logic stop_done;            // stopped long enough for the test
    } dft_state_t;

    dft_state_t st, next_st;

    // raw fault pins gathered, synchronised as one vector
    logic [NF-1:0] raw;
    assign raw = {emergency_stop, cpu_fault, driver_path_error, mem_fault,
                  ground_fault, over_current, bus_over_voltage, bus_under_voltage,
                  motor_overload, module_over_temp, thermistor_hot,
                  external_trip_input, comm_watchdog_expired,
                  brownout_restart_failed, input_over_voltage,
                  run_command, power_up_test, reset_input_terminal};

    // synchronised named views
    logic f_estop, f_cpu, f_drv, f_mem, f_gnd, f_oc, f_bov, f_buv, f_ovl;
    logic f_mod, f_thm, f_ext, f_comm, f_brown, f_inov, s_run, s_pwr, s_rs;
    assign {f_estop, f_cpu, f_drv, f_mem, f_gnd, f_oc, f_bov, f_buv, f_ovl,
            f_mod, f_thm, f_ext, f_comm, f_brown, f_inov, s_run, s_pwr, s_rs} = st.s2;

    // fault select and code
    logic fault_now;
    logic [7:0] fault_code;
    logic key_press;
    logic init_press;

    // priority encoder of active faults to a code
    always_comb begin
        fault_now = 1'b1;
        fault_code = DFT_CODE_NONE;
        if (f_estop) begin
            fault_code = DFT_CODE_ESTOP;
        end else if (f_cpu) begin
            fault_code = DFT_CODE_CPU;
        end else if (f_drv) begin
            fault_code = DFT_CODE_DRIVER;
        end else if (f_mem || (st.first && reset_held_at_power_off)) begin
            fault_code = DFT_CODE_MEM;
        end else if (f_gnd && s_pwr) begin
            fault_code = DFT_CODE_GROUND;
        end else if (f_oc) begin
            // code follows the motion phase at detection
            case (st.ph2)
                DFT_PHASE_CONST: fault_code = DFT_CODE_OC_CONST;
                DFT_PHASE_DECEL: fault_code = DFT_CODE_OC_DECEL;
                DFT_PHASE_ACCEL: fault_code = DFT_CODE_OC_ACCEL;
                default: fault_code = DFT_CODE_OC_OTHER;
            endcase
        end else if (f_bov) begin
            fault_code = DFT_CODE_BUS_OV;
        end else if (f_buv) begin
            fault_code = DFT_CODE_BUS_UV;
        end else if (f_brown) begin
            fault_code = DFT_CODE_BUS_UV;
        end else if (f_ovl) begin
            fault_code = DFT_CODE_OVERLOAD;
        end else if (f_mod) begin
            fault_code = DFT_CODE_MOD_HOT;
        end else if (f_thm) begin
            fault_code = DFT_CODE_THERMISTOR;
        end else if (f_ext) begin
            fault_code = DFT_CODE_EXT;
        end else if (f_comm) begin
            fault_code = DFT_CODE_COMM;
        end else if (st.first && unattended_start_guard && s_run) begin
            fault_code = DFT_CODE_START;
        end else if (st.stop_done && f_inov) begin
            fault_code = DFT_CODE_IN_OV;
        end else begin
            fault_now = 1'b0;
        end
    end

    // next-state logic
    always_comb begin
        next_st = st;
        key_press = st.key2 && !st.key3;
        init_press = st.init2 && !st.init3;
        // synchroniser chains
        next_st.s1 = raw;
        next_st.s2 = st.s1;
        next_st.ph1 = motion_phase;
        next_st.ph2 = st.ph1;
        next_st.key1 = stop_reset_key;
        next_st.key2 = st.key1;
        next_st.key3 = st.key2;
        next_st.init1 = init_execute;
        next_st.init2 = st.init1;
        next_st.init3 = st.init2;
        // power-up checks wait until the run pin has crossed both sync flops
        next_st.boot1 = 1'b0;
        next_st.boot2 = st.boot1;
        next_st.first = st.boot2;
        // stopped-time counter, reset whenever the motor runs
        if (motor_running) begin
            next_st.stop_cnt = '0;
            next_st.stop_done = 1'b0;
        end else if (st.stop_cnt >= STOP_TEST_CYC[DFT_STOP_CNT_W-1:0] - 1'b1) begin
            next_st.stop_done = 1'b1;
        end else begin
            next_st.stop_cnt = st.stop_cnt + 1'b1;
        end
        // history clear by init select 00
        if (init_press && init_select_setting == DFT_INIT_CLEAR_HISTORY) begin
            next_st.h0 = DFT_RST_CODE;
            next_st.h1 = DFT_RST_CODE;
            next_st.h2 = DFT_RST_CODE;
        end
        // key press clears the trip, run or stop alike
        if (st.tripped && key_press) begin
            next_st.tripped = 1'b0;
            next_st.oe = 1'b1;
            next_st.code = DFT_CODE_NONE;
            next_st.stop_cnt = '0;
            next_st.stop_done = 1'b0;
        end
        // a new fault trips; set wins over a clear in the same cycle
        if (fault_now && (!st.tripped || key_press)) begin
            next_st.tripped = 1'b1;
            next_st.oe = 1'b0;
            next_st.code = fault_code;
            next_st.snap = operating_data;
            next_st.h0 = fault_code;
            next_st.h1 = st.h0;
            next_st.h2 = st.h1;
        end
        // while tripped output stays off and code holds
        if (st.tripped && !key_press) begin
            next_st.oe = 1'b0;
        end
    end

    // state register
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st <= '0;
            st.boot1 <= 1'b1;
            st.code <= DFT_RST_CODE;
            st.snap <= DFT_RST_SNAP;
            st.oe <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from the state register
    always_comb begin
        tripped = st.tripped;
        output_enable = st.oe;
        run_allowed = st.oe;
        display_code = st.code;
        fault_snapshot = st.snap;
        newest_fault_record = st.h0;
        middle_fault_record = st.h1;
        oldest_fault_record = st.h2;
    end

    // a trip turns the output off on the next edge and keeps the code
    property p_trip_off;
        @(posedge ref_clk) disable iff (rst)
        (fault_now && !st.tripped) |=> (tripped && !output_enable && display_code == $past(fault_code));
    endproperty
    a_trip_off: assert property (p_trip_off) else $error("trip did not latch");

    property p_hold;
        @(posedge ref_clk) disable iff (rst)
        (tripped && !key_press) |=> (tripped && display_code == $past(display_code));
    endproperty
    a_hold: assert property (p_hold) else $error("trip not held");

    property p_clear;
        @(posedge ref_clk) disable iff (rst)
        (tripped && key_press && !fault_now) |=> (!tripped && output_enable);
    endproperty
    a_clear: assert property (p_clear) else $error("key did not clear");

    property p_shift;
        @(posedge ref_clk) disable iff (rst)
        (fault_now && !st.tripped) |=> (middle_fault_record == $past(newest_fault_record)
            && oldest_fault_record == $past(middle_fault_record));
    endproperty
    a_shift: assert property (p_shift) else $error("history did not shift");

    property p_hist_clr;
        @(posedge ref_clk) disable iff (rst)
        (init_press && init_select_setting == DFT_INIT_CLEAR_HISTORY && !fault_now)
            |=> (newest_fault_record == 8'h00 && middle_fault_record == 8'h00
                && oldest_fault_record == 8'h00);
    endproperty
    a_hist_clr: assert property (p_hist_clr) else $error("history not erased");

    property p_oc_code;
        @(posedge ref_clk) disable iff (rst)
        (fault_now && !st.tripped && fault_code inside {8'h01, 8'h02, 8'h03, 8'h04})
            |-> (f_oc && fault_code == ((st.ph2 == DFT_PHASE_CONST) ? 8'h01 :
                 (st.ph2 == DFT_PHASE_DECEL) ? 8'h02 :
                 (st.ph2 == DFT_PHASE_ACCEL) ? 8'h03 : 8'h04));
    endproperty
    a_oc_code: assert property (p_oc_code) else $error("bad over-current code");

    property p_snap;
        @(posedge ref_clk) disable iff (rst)
        (fault_now && !st.tripped) |=> (fault_snapshot == $past(operating_data));
    endproperty
    a_snap: assert property (p_snap) else $error("snapshot missed");

    property p_estop;
        @(posedge ref_clk) disable iff (rst)
        (f_estop && !st.tripped) |=> (display_code == 8'h37);
    endproperty
    a_estop: assert property (p_estop) else $error("estop code wrong");

    property p_inov;
        @(posedge ref_clk) disable iff (rst)
        (display_code == 8'h15 && $changed(display_code)) |-> $past(st.stop_done);
    endproperty
    a_inov: assert property (p_inov) else $error("early input ov test");

    // reset terminal held at power-off raises the memory fault at power-up
    property p_mem_boot;
        @(posedge ref_clk) disable iff (rst)
        (st.first && reset_held_at_power_off && !f_estop && !f_cpu && !f_drv)
            |=> (tripped && display_code == DFT_CODE_MEM);
    endproperty
    a_mem_boot: assert property (p_mem_boot) else $error("memory boot trip missed");

    // a held trip keeps the run permission withdrawn
    property p_no_run;
        @(posedge ref_clk) disable iff (rst)
        (tripped && !key_press) |=> !run_allowed;
    endproperty
    a_no_run: assert property (p_no_run) else $error("run allowed while tripped");

    // a running motor restarts the stopped-time count
    property p_stop_clr;
        @(posedge ref_clk) disable iff (rst)
        motor_running |=> !st.stop_done;
    endproperty
    a_stop_clr: assert property (p_stop_clr) else $error("stop count kept");

    // a fault taken while not yet tripped
    sequence s_fresh_trip;
        fault_now && !st.tripped;
    endsequence

    // the newest record names the code on show after a fresh trip
    property p_newest;
        @(posedge ref_clk) disable iff (rst)
        s_fresh_trip |=> (newest_fault_record == display_code);
    endproperty
    a_newest: assert property (p_newest) else $error("newest record wrong");

    // rising key as seen behind the synchroniser, two samples long
    sequence s_key_rise;
        !st.key2 ##1 st.key2;
    endsequence

    // a key press with no fault pending ends the trip
    property p_key_clear;
        @(posedge ref_clk) disable iff (rst)
        s_key_rise ##0 (tripped && !fault_now) |=> !tripped;
    endproperty
    a_key_clear: assert property (p_key_clear) else $error("key edge ignored");
endmodule
`default_nettype wire

//--- sim/dft_far_side.sv
`timescale 1ns/1ps
`default_nettype none
// output stage and keypad as seen from the trip block
module dft_far_side (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // output stage side
    input wire logic output_enable,
    input wire logic run_command,
    output logic motor_running,
    // keypad side
    input wire logic press,
    output logic stop_reset_key
);
    logic [2:0] hold; // cycles left with the key held down
    // motor turns only while the stage is enabled and run is asked
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            motor_running <= 1'b0;
            hold <= 3'h0;
        end else begin
            motor_running <= output_enable & run_command;
            // one press holds the key for four cycles
            if (press) begin
                hold <= 3'h4;
            end else if (hold != 3'h0) begin
                hold <= hold - 3'h1;
            end
        end
    end
    assign stop_reset_key = (hold != 3'h0);
endmodule
`default_nettype wire

//--- sim/drive_fault_trip_history_tb.sv
`timescale 1ns/1ps
`default_nettype none
module drive_fault_trip_history_tb import dft_pkg::*; ;
    logic ref_clk, rst, press, run_command, unattended_start_guard;
    logic reset_held_at_power_off, power_up_test, init_execute, prv;
    logic [14:0] flt; // fault pins, one bit each
    logic [1:0] motion_phase, init_select_setting;
    logic [15:0] operating_data, fault_snapshot;
    wire logic motor_running, stop_reset_key;
    logic tripped, output_enable, run_allowed;
    logic [7:0] display_code, newest, middle, oldest;
    logic [7:0] hist [3]; // expected history, newest first
    logic [47:0] expq [$]; // expected trip records
    logic [47:0] e;
    int num_errors, n_checks;
    dft_trip #(.STOP_TEST_CYC(20)) dut_u (.ref_clk(ref_clk), .rst(rst),
        .over_current(flt[0]), .motion_phase(motion_phase), .motor_overload(flt[1]),
        .bus_over_voltage(flt[2]), .bus_under_voltage(flt[3]), .mem_fault(flt[4]),
        .cpu_fault(flt[5]), .external_trip_input(flt[6]), .ground_fault(flt[7]),
        .input_over_voltage(flt[8]), .module_over_temp(flt[9]), .thermistor_hot(flt[10]),
        .driver_path_error(flt[11]), .emergency_stop(flt[12]),
        .comm_watchdog_expired(flt[13]), .brownout_restart_failed(flt[14]),
        .run_command(run_command), .motor_running(motor_running),
        .unattended_start_guard(unattended_start_guard), .reset_input_terminal(1'b0),
        .reset_held_at_power_off(reset_held_at_power_off), .power_up_test(power_up_test),
        .stop_reset_key(stop_reset_key), .init_select_setting(init_select_setting),
        .init_execute(init_execute), .operating_data(operating_data), .tripped(tripped),
        .output_enable(output_enable), .run_allowed(run_allowed),
        .display_code(display_code), .fault_snapshot(fault_snapshot),
        .newest_fault_record(newest), .middle_fault_record(middle),
        .oldest_fault_record(oldest));
    dft_far_side far_u (.ref_clk(ref_clk), .rst(rst), .output_enable(output_enable),
        .run_command(run_command), .motor_running(motor_running), .press(press),
        .stop_reset_key(stop_reset_key));
    // free running clock
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    // expected code for each fault pin
    function automatic logic [7:0] code_of(int i, logic [1:0] ph);
        case (i)
            0: code_of = (ph == DFT_PHASE_CONST) ? DFT_CODE_OC_CONST :
                (ph == DFT_PHASE_DECEL) ? DFT_CODE_OC_DECEL :
                (ph == DFT_PHASE_ACCEL) ? DFT_CODE_OC_ACCEL : DFT_CODE_OC_OTHER;
            1: code_of = DFT_CODE_OVERLOAD;
            2: code_of = DFT_CODE_BUS_OV;
            3: code_of = DFT_CODE_BUS_UV;
            4: code_of = DFT_CODE_MEM;
            5: code_of = DFT_CODE_CPU;
            6: code_of = DFT_CODE_EXT;
            7: code_of = DFT_CODE_GROUND;
            8: code_of = DFT_CODE_IN_OV;
            9: code_of = DFT_CODE_MOD_HOT;
            10: code_of = DFT_CODE_THERMISTOR;
            11: code_of = DFT_CODE_DRIVER;
            12: code_of = DFT_CODE_ESTOP;
            13: code_of = DFT_CODE_COMM;
            default: code_of = DFT_CODE_BUS_UV;
        endcase
    endfunction
    // compare and count
    task automatic chk(string nm, logic [47:0] seen, logic [47:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // step n edges, then drive just after the edge
    task automatic tick(int n);
        repeat (n) @(posedge ref_clk);
        #5;
    endtask
    // verdict and end of run
    task automatic final_report();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // press the key and expect the trip gone, output back on
    task automatic clear();
        press = 1'b1;
        tick(1);
        press = 1'b0;
        tick(10);
        chk("cleared", {37'h0, tripped, output_enable, run_allowed, display_code},
            {37'h0, 3'b011, DFT_CODE_NONE});
    endtask
    // power-up with given start conditions and expected trip code
    task automatic boot(logic guard, logic held, logic [7:0] c);
        rst = 1'b1;
        unattended_start_guard = guard;
        run_command = guard;
        reset_held_at_power_off = held;
        operating_data = 16'($urandom);
        tick(3);
        chk("in reset", {display_code, newest, middle, oldest, fault_snapshot}, 48'h0);
        hist = '{c, 8'h00, 8'h00};
        expq.push_back({c, c, 16'h0, operating_data});
        rst = 1'b0;
        tick(12);
        reset_held_at_power_off = 1'b0;
        clear();
    endtask
    // raise one fault pin, wait for the trip, add a refused fault, clear
    task automatic fire(int i, logic [1:0] ph, logic run);
        logic [7:0] c;
        int k;
        c = code_of(i, ph);
        run_command = run;
        motion_phase = ph;
        power_up_test = (i == 7);
        operating_data = 16'($urandom);
        hist[2] = hist[1];
        hist[1] = hist[0];
        hist[0] = c;
        expq.push_back({c, hist[0], hist[1], hist[2], operating_data});
        flt[i] = 1'b1;
        k = 0;
        while (tripped !== 1'b1 && k < 60) begin
            tick(1);
            k++;
        end
        chk("trip seen", {47'h0, tripped}, 48'h1);
        flt[(i + 5) % 15] = 1'b1;
        tick(2);
        flt = '0;
        tick(8);
        chk("latched", {39'h0, tripped, display_code}, {39'h0, 1'b1, c});
        clear();
    endtask
    // history erase by init with a given select value
    task automatic erase(logic [1:0] sel);
        init_select_setting = sel;
        init_execute = 1'b1;
        tick(4);
        init_execute = 1'b0;
        tick(6);
        if (sel == DFT_INIT_CLEAR_HISTORY) begin
            hist = '{8'h00, 8'h00, 8'h00};
        end
        chk("history", {24'h0, newest, middle, oldest},
            {24'h0, hist[0], hist[1], hist[2]});
    endtask
    // watcher: each rising trip takes the oldest note and compares
    initial begin
        prv = 1'b0;
        forever begin
            @(negedge ref_clk);
            if (tripped === 1'b1 && prv !== 1'b1) begin
                if (expq.size() == 0) begin
                    chk("unexpected trip", {40'h0, display_code}, 48'h0);
                end else begin
                    e = expq.pop_front();
                    chk("trip record", {display_code, newest, middle, oldest,
                        fault_snapshot}, e);
                    chk("output off", {46'h0, output_enable, run_allowed}, 48'h0);
                end
            end
            prv = tripped;
        end
    end
    // watchdog on a hang
    initial begin
        #(30000 * 100);
        num_errors++;
        $display("mismatch watchdog expected done seen hang");
        final_report();
    end
    // main sequence
    initial begin
        flt = '0;
        press = 1'b0;
        motion_phase = 2'h0;
        power_up_test = 1'b0;
        init_execute = 1'b0;
        init_select_setting = 2'h0;
        num_errors = 0;
        n_checks = 0;
        void'($urandom(2904));
        boot(1'b1, 1'b0, DFT_CODE_START);
        for (int p = 0; p < 4; p++) fire(0, 2'(p), 1'($urandom));
        for (int i = 1; i < 15; i++) if (i != 8) fire(i, 2'($urandom), 1'($urandom));
        run_command = 1'b1;
        flt[8] = 1'b1;
        tick(40);
        chk("no test while running", {47'h0, tripped}, 48'h0);
        fire(8, 2'h0, 1'b0);
        erase(2'h1 + 2'($urandom % 3));
        erase(DFT_INIT_CLEAR_HISTORY);
        boot(1'b0, 1'b1, DFT_CODE_MEM);
        chk("notes left", 48'(expq.size()), 48'h0);
        final_report();
    end
endmodule
`default_nettype wire
